// >>> hw/drc_params.svh
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// register port indices
`define DRC_IDX_BASE 2'h0
`define DRC_IDX_TIME 2'h1
`define DRC_IDX_CON 2'h2

// field layout
`define DRC_BASE_W 7
`define DRC_CNT_W 9
`define DRC_EN_BIT 15

// reset values
`define DRC_BASE_RST 7'h00
`define DRC_TIME_RST 9'h000
`define DRC_CNT_RST 9'h000
`define DRC_ROW_RST 9'h000

// refresh address constant fields
`define DRC_RA_MID 3'h0
`define DRC_RA_BIT0 1'h1

// refresh bus cycle: four clock_output periods of two mclk each
`define DRC_REF_LEN 4'h8

`endif

// >>> hw/drc_pkg.sv
package drc_pkg;
    typedef enum logic [1:0] {
        DRC_ST_IDLE,
        DRC_ST_GRANT,
        DRC_ST_RECLAIM,
        DRC_ST_REFRESH
    } drc_bus_state_t;
endpackage

// >>> hw/drc_sync3.sv
`timescale 1ns/1ps
module drc_sync3 (
    input wire logic mclk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic din, // asynchronous pin level
    output logic dout // filtered synchronous level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_comb begin
        out_next = out_reg;
        if (s2_reg == s3_reg) begin
            out_next = s3_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule

// >>> hw/drc_row_lfsr.sv
`timescale 1ns/1ps
`include "drc_params.svh"
module drc_row_lfsr (
    input wire logic mclk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic advance, // step to the next row
    output logic [8:0] row // current row value
);
    logic [8:0] row_reg;
    logic [8:0] row_next;
    logic fb;

    // x^9+x^5+1 with the zero-state insertion so all 512 values occur
    always_comb begin
        fb = row_reg[8] ^ row_reg[4] ^ (row_reg[7:0] == 8'h00);
        row_next = row_reg;
        if (advance) begin
            row_next = {row_reg[7:0], fb};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            row_reg <= `DRC_ROW_RST;
        end else begin
            row_reg <= row_next;
        end
    end

    assign row = row_reg;
endmodule

// >>> hw/drc_refresh_ctrl.sv
`timescale 1ns/1ps
`include "drc_params.svh"
module drc_refresh_ctrl #(
    parameter bit BUS_8BIT = 1'b0 // 1: 8-bit bus variant
) (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic nrst, // async reset, active low
    input wire logic [1:0] reg_sel, // register index
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [15:0] reg_wdata, // register write data
    output logic [15:0] reg_rdata, // registered read data
    input wire logic hold_request, // alternate master bus request pin
    output logic hold_acknowledge, // bus granted to alternate master
    output logic clock_output, // divided processor clock output
    output logic refresh_cycle, // refresh bus cycle in progress
    output logic [19:0] refresh_addr, // address of refresh cycle
    output logic refresh_strobe_n, // refresh strobe, 8-bit variant
    output logic byte_high_enable_n, // byte high enable, 16-bit variant
    output logic refresh_pending // unserviced refresh request
);
    logic [6:0] base_reg;
    logic [6:0] base_next;
    logic [8:0] time_reg;
    logic [8:0] time_next;
    logic en_reg;
    logic en_next;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic clk_reg;
    logic clk_next;
    logic pend_reg;
    logic pend_next;
    logic req_pulse;
    logic step;
    logic con_wr;

    drc_pkg::drc_bus_state_t state_reg;
    drc_pkg::drc_bus_state_t state_next;
    logic [3:0] len_reg;
    logic [3:0] len_next;
    logic ack_reg;
    logic ack_next;
    logic rcyc_reg;
    logic rcyc_next;
    logic [19:0] addr_reg;
    logic [19:0] addr_next;
    logic refresh_strobe_n_n_reg;
    logic refresh_strobe_n_n_next;
    logic bhe_n_reg;
    logic bhe_n_next;
    logic hold_s;
    logic start_ref;
    logic end_ref;
    logic [8:0] row;

    // hold_s trails the pin by three to four cycles
    drc_sync3 u_hold_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(hold_request),
        .dout(hold_s)
    );

    // row moves only once a refresh cycle has run
    drc_row_lfsr u_row (
        .mclk(mclk),
        .nrst(nrst),
        .advance(end_ref),
        .row(row)
    );

    // clock_output falls when clk_reg goes 1 -> 0; step on that edge
    always_comb begin
        clk_next = ~clk_reg;
        step = clk_reg;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clk_reg <= 1'b0;
        end else begin
            clk_reg <= clk_next;
        end
    end

    // register file; writes land at the next edge
    always_comb begin
        con_wr = reg_wr && (reg_sel == `DRC_IDX_CON);
        base_next = base_reg;
        time_next = time_reg;
        en_next = en_reg;
        // reserved write bits are simply dropped
        if (reg_wr && (reg_sel == `DRC_IDX_BASE)) begin
            base_next = reg_wdata[6:0];
        end
        if (reg_wr && (reg_sel == `DRC_IDX_TIME)) begin
            time_next = reg_wdata[8:0];
        end
        if (con_wr) begin
            en_next = reg_wdata[`DRC_EN_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            base_reg <= `DRC_BASE_RST;
            time_reg <= `DRC_TIME_RST;
            en_reg <= 1'b0;
        end else begin
            base_reg <= base_next;
            time_reg <= time_next;
            en_reg <= en_next;
        end
    end

    // down-counter; software never writes these bits
    always_comb begin
        req_pulse = 1'b0;
        cnt_next = cnt_reg;
        if (!en_next) begin
            cnt_next = `DRC_CNT_RST;
        end else if (!en_reg) begin
            cnt_next = time_next;
        end else if (step) begin
            if (cnt_reg == 9'h001) begin
                req_pulse = 1'b1;
                cnt_next = time_reg;
            end else if (cnt_reg == 9'h000) begin
                // a zero interval keeps reloading and never requests
                cnt_next = time_reg;
            end else begin
                cnt_next = cnt_reg - 9'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= `DRC_CNT_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // read data stands until the next read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_sel)
                `DRC_IDX_BASE: rdata_next = {9'h000, base_reg};
                `DRC_IDX_TIME: rdata_next = {7'h00, time_reg};
                `DRC_IDX_CON: rdata_next = {en_reg, 6'h00, cnt_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // single pending flag: a new request overwrites, set beats clear
    always_comb begin
        pend_next = pend_reg;
        if (start_ref) begin
            pend_next = 1'b0;
        end
        if (!en_reg) begin
            pend_next = 1'b0;
        end
        if (req_pulse) begin
            pend_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // bus ownership between refresh and the alternate master
    always_comb begin
        state_next = state_reg;
        len_next = len_reg;
        start_ref = 1'b0;
        end_ref = 1'b0;
        unique case (state_reg)
            drc_pkg::DRC_ST_IDLE: begin
                // refresh wins a tie so rows are not starved
                if (pend_reg) begin
                    start_ref = 1'b1;
                end else if (hold_s) begin
                    state_next = drc_pkg::DRC_ST_GRANT;
                end
            end
            drc_pkg::DRC_ST_GRANT: begin
                if (!hold_s) begin
                    state_next = drc_pkg::DRC_ST_IDLE;
                end else if (pend_reg) begin
                    state_next = drc_pkg::DRC_ST_RECLAIM;
                end
            end
            drc_pkg::DRC_ST_RECLAIM: begin
                // the far side must drop its request in bounded time
                if (!hold_s) begin
                    start_ref = 1'b1;
                end
            end
            drc_pkg::DRC_ST_REFRESH: begin
                if (len_reg == 4'h1) begin
                    end_ref = 1'b1;
                    state_next = drc_pkg::DRC_ST_IDLE;
                end else begin
                    len_next = len_reg - 4'h1;
                end
            end
        endcase
        if (start_ref) begin
            state_next = drc_pkg::DRC_ST_REFRESH;
            len_next = `DRC_REF_LEN;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= drc_pkg::DRC_ST_IDLE;
            len_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            len_reg <= len_next;
        end
    end

    // outputs follow the next state so every pin leaves a flip-flop
    always_comb begin
        ack_next = (state_next == drc_pkg::DRC_ST_GRANT);
        rcyc_next = (state_next == drc_pkg::DRC_ST_REFRESH);
        addr_next = 20'h00000;
        refresh_strobe_n_n_next = 1'b1;
        bhe_n_next = 1'b1;
        if (rcyc_next) begin
            // base is never bumped on a row wrap
            addr_next = {base_reg, `DRC_RA_MID, row, `DRC_RA_BIT0};
            refresh_strobe_n_n_next = ~BUS_8BIT;
            bhe_n_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rcyc_reg <= 1'b0;
            addr_reg <= 20'h00000;
            refresh_strobe_n_n_reg <= 1'b1;
            bhe_n_reg <= 1'b1;
        end else begin
            ack_reg <= ack_next;
            rcyc_reg <= rcyc_next;
            addr_reg <= addr_next;
            refresh_strobe_n_n_reg <= refresh_strobe_n_n_next;
            bhe_n_reg <= bhe_n_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign hold_acknowledge = ack_reg;
    assign clock_output = clk_reg;
    assign refresh_cycle = rcyc_reg;
    assign refresh_addr = addr_reg;
    assign refresh_strobe_n = refresh_strobe_n_n_reg;
    assign byte_high_enable_n = bhe_n_reg;
    assign refresh_pending = pend_reg;
endmodule

// >>> test/drc_refresh_chk.sv
`timescale 1ns/1ps
module drc_refresh_chk (
    input wire logic mclk, // clock
    input wire logic nrst, // reset
    input wire logic [1:0] reg_sel, // index
    input wire logic reg_rd, // read
    input wire logic [15:0] reg_rdata, // data
    input wire logic hold_request, // hold in
    input wire logic hold_acknowledge, // grant
    input wire logic refresh_cycle, // refresh
    input wire logic [19:0] refresh_addr, // address
    input wire logic byte_high_enable_n, // byte high enable
    input wire logic refresh_pending // request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_base_rd;
        reg_rd && reg_sel == 2'h0 |=> reg_rdata[15:7] == 9'h000;
    endproperty
    a_base_rd: assert property (p_base_rd)
        else $error("base read shows reserved bits");
    property p_con_rd;
        reg_rd && reg_sel == 2'h2 |=> reg_rdata[14:9] == 6'h00;
    endproperty
    a_con_rd: assert property (p_con_rd)
        else $error("control read shows reserved bits");
    property p_ref_addr;
        refresh_cycle |-> refresh_addr[12:10] == 3'h0 && refresh_addr[0];
    endproperty
    a_ref_addr: assert property (p_ref_addr)
        else $error("refresh address fixed fields wrong");
    property p_addr_idle;
        !refresh_cycle |-> refresh_addr == 20'h00000;
    endproperty
    a_addr_idle: assert property (p_addr_idle)
        else $error("address outside refresh");
    property p_ref_bhe;
        refresh_cycle |-> byte_high_enable_n;
    endproperty
    a_ref_bhe: assert property (p_ref_bhe)
        else $error("byte high enable low in refresh");
    property p_ref_noack;
        refresh_cycle |-> !hold_acknowledge;
    endproperty
    a_ref_noack: assert property (p_ref_noack)
        else $error("bus granted during refresh");
    property p_ack_drop;
        hold_acknowledge && refresh_pending |=> !hold_acknowledge;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("grant kept with refresh pending");
    property p_ack_keep;
        hold_request[*5] ##0 (hold_acknowledge && !refresh_pending)
            |=> hold_acknowledge;
    endproperty
    a_ack_keep: assert property (p_ack_keep)
        else $error("grant dropped while hold held");
    property p_ref_start;
        $rose(refresh_cycle) |-> !$past(hold_acknowledge);
    endproperty
    a_ref_start: assert property (p_ref_start)
        else $error("refresh started while granted");
    c_ref: cover property ($rose(refresh_cycle));
    c_drop: cover property (hold_acknowledge && refresh_pending);
    c_rd: cover property (reg_rd && reg_sel == 2'h2);
endmodule
bind drc_refresh_ctrl drc_refresh_chk u_chk (
    .mclk(mclk),
    .nrst(nrst),
    .reg_sel(reg_sel),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .hold_request(hold_request),
    .hold_acknowledge(hold_acknowledge),
    .refresh_cycle(refresh_cycle),
    .refresh_addr(refresh_addr),
    .byte_high_enable_n(byte_high_enable_n),
    .refresh_pending(refresh_pending)
);

// >>> test/drc_alt_master.sv
`timescale 1ns/1ps
module drc_alt_master (
    input wire logic mclk, // clock
    input wire logic nrst, // reset
    input wire logic want, // bus wanted
    input wire logic [3:0] lag, // release delay
    input wire logic hold_acknowledge, // grant
    output logic hold_request // request
);
    logic req_reg, req_next, had_reg, had_next;
    logic [3:0] cnt_reg, cnt_next;
    assign hold_request = req_reg;
    always_comb begin
        req_next = req_reg;
        had_next = had_reg | (req_reg & hold_acknowledge);
        cnt_next = cnt_reg;
        if (!req_reg) begin
            if (cnt_reg != 4'h0)
                cnt_next = cnt_reg - 4'h1;
            else
                req_next = want;
        end else if (!want || (had_reg && !hold_acknowledge)) begin
            // slow masters dawdle up to lag cycles
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg >= lag) begin
                req_next = 1'b0;
                had_next = 1'b0;
                cnt_next = 4'h2;
            end
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_reg <= 1'b0;
            had_reg <= 1'b0;
            cnt_reg <= 4'h0;
        end else begin
            req_reg <= req_next;
            had_reg <= had_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// >>> test/tb_dram_refresh_control.sv
`timescale 1ns/1ps
module tb_dram_refresh_control;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic hold_request, hold_acknowledge, clock_output, refresh_cycle;
    logic [19:0] refresh_addr;
    logic refresh_strobe_n, byte_high_enable_n, refresh_pending;
    logic want = 1'b0;
    logic [3:0] lag = 4'h0;
    logic clk_d = 1'b0;
    logic rcyc8_d = 1'b0;
    logic rfsh8_n, bhe8_n, rcyc8;
    logic [19:0] addr8;
    logic rd_seen = 1'b0;
    logic pend_d = 1'b0;
    logic ref_d = 1'b0;
    logic [6:0] base = 7'h00;
    logic [8:0] n = 9'h000;
    logic [8:0] last_row = 9'h000;
    logic [15:0] exp_q[$];
    int bad_count = 0, compares = 0, cyc = 0, last_p = 0, per = 0;
    int nref = 0, n0 = 0, k = 0;
    always #5 mclk = ~mclk;
    drc_refresh_ctrl DUT (
        .mclk(mclk),
        .nrst(nrst),
        .reg_sel(reg_sel),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .hold_request(hold_request),
        .hold_acknowledge(hold_acknowledge),
        .clock_output(clock_output),
        .refresh_cycle(refresh_cycle),
        .refresh_addr(refresh_addr),
        .refresh_strobe_n(refresh_strobe_n),
        .byte_high_enable_n(byte_high_enable_n),
        .refresh_pending(refresh_pending)
    );
    // 8-bit bus variant, same stimulus, only its refresh pins watched
    drc_refresh_ctrl #(
        .BUS_8BIT(1'b1)
    ) DUT8 (
        .mclk(mclk),
        .nrst(nrst),
        .reg_sel(reg_sel),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(),
        .hold_request(hold_request),
        .hold_acknowledge(),
        .clock_output(),
        .refresh_cycle(rcyc8),
        .refresh_addr(addr8),
        .refresh_strobe_n(rfsh8_n),
        .byte_high_enable_n(bhe8_n),
        .refresh_pending()
    );
    drc_alt_master u_alt (
        .mclk(mclk),
        .nrst(nrst),
        .want(want),
        .lag(lag),
        .hold_acknowledge(hold_acknowledge),
        .hold_request(hold_request)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        compares++;
        if (got !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        @(negedge mclk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    // no lead-in wait, so a read lands right after a write
    task automatic rd(input logic [1:0] s, input logic [15:0] e);
        reg_sel = s;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
    endtask
    task automatic wait_ack(input logic v);
        k = 0;
        while (hold_acknowledge !== v && k < 300) begin
            @(negedge mclk);
            k++;
        end
        chk({15'h0000, hold_acknowledge}, {15'h0000, v});
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (rd_seen)
            chk(reg_rdata, exp_q.pop_front());
        rd_seen = reg_rd;
        if (refresh_pending && !pend_d && per != 0) begin
            if (last_p != 0)
                chk(16'(cyc - last_p), 16'(per));
            last_p = cyc;
        end
        if (refresh_cycle && !ref_d) begin
            nref++;
            chk({9'h000, refresh_addr[19:13]}, {9'h000, base});
            chk({refresh_strobe_n, byte_high_enable_n}, 16'h0003);
            if (nref > 1)
                chk(16'(refresh_addr[9:1] == last_row), 16'h0000);
            last_row = refresh_addr[9:1];
        end
        pend_d = refresh_pending;
        ref_d = refresh_cycle;
        if (cyc > 5)
            chk({15'h0000, clock_output}, {15'h0000, ~clk_d});
        clk_d = clock_output;
        if (rcyc8 && !rcyc8_d)
            chk({13'h0000, rfsh8_n, bhe8_n, addr8[0]}, 16'h0003);
        rcyc8_d = rcyc8;
    end
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h98A7));
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++)
            rd(2'(i), 16'h0000);
        wr(2'h3, 16'hFFFF);
        rd(2'h3, 16'h0000);
        wr(2'h0, 16'h007F);
        rd(2'h0, 16'h007F);
        wr(2'h1, 16'h01FF);
        rd(2'h1, 16'h01FF);
        wr(2'h2, 16'h01FF);
        rd(2'h2, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            n = 9'(8 + $urandom % 24);
            base = 7'($urandom);
            wr(2'h0, {9'h000, base});
            wr(2'h1, {7'h00, n});
            last_p = 0;
            per = 2 * n;
            n0 = nref;
            wr(2'h2, 16'h8000);
            rd(2'h2, {7'h40, n});
            repeat (8 * n + 40) @(negedge mclk);
            chk(16'(nref - n0 >= 3), 16'h0001);
            per = 0;
            wr(2'h2, 16'h0000);
            rd(2'h2, 16'h0000);
        end
        $display("test interval done");
        for (int i = 0; i < 2; i++) begin
            lag = i ? 4'h9 : 4'h0;
            wr(2'h1, 16'h0014);
            wr(2'h2, 16'h8000);
            want = 1'b1;
            wait_ack(1'b1);
            n0 = nref;
            wait_ack(1'b0);
            k = 0;
            while (nref == n0 && k < 300) begin
                @(negedge mclk);
                k++;
            end
            chk(16'(nref > n0), 16'h0001);
            wait_ack(1'b1);
            want = 1'b0;
            wr(2'h2, 16'h0000);
            repeat (20) @(negedge mclk);
        end
        $display("test hold done");
        complete_run();
    end
endmodule
